// >>> hw/mfesd_defines.vh
// Purpose: Offsets, field positions and reset values of the media front end state decoder.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes:   Included by the decoder and by the picture parameter module.
`ifndef MFESD_DEFINES_VH
`define MFESD_DEFINES_VH

`define MFESD_ADDR_FES_W0     6'h00
`define MFESD_ADDR_FES_W1     6'h04
`define MFESD_ADDR_FES_W2     6'h08
`define MFESD_ADDR_DSD_W0     6'h0C
`define MFESD_ADDR_DSD_W1     6'h10
`define MFESD_ADDR_GS_BASE    6'h14
`define MFESD_ADDR_EXT_PTR    6'h18
`define MFESD_ADDR_APPLY      6'h1C
`define MFESD_ADDR_STATUS     6'h20
`define MFESD_ADDR_INDEX      6'h24

`define MFESD_WORD_RESET      32'h00000000

`define MFESD_SCRATCH_MSB     31
`define MFESD_SCRATCH_LSB     10
`define MFESD_EXT_BIT         7
`define MFESD_PTS_MSB         3
`define MFESD_PTS_LSB         0
`define MFESD_PTS_MAX         4'hB
`define MFESD_THR_MSB         31
`define MFESD_THR_LSB         25
`define MFESD_URB_SIZE_MSB    24
`define MFESD_URB_SIZE_LSB    16
`define MFESD_URB_SIZE_MAX    9'h0FF
`define MFESD_URB_CNT_MSB     15
`define MFESD_URB_CNT_LSB     9
`define MFESD_URB_CNT_MIN     7'h01
`define MFESD_URB_CNT_MAX     7'h40
`define MFESD_MODE_MSB        6
`define MFESD_MODE_LSB        3
`define MFESD_CHILD_BIT       2
`define MFESD_KD_MSB          31
`define MFESD_KD_LSB          4

`define MFESD_MODE_GENERIC    4'h0
`define MFESD_MODE_VLD        4'h1
`define MFESD_MODE_IS         4'h2
`define MFESD_MODE_AVC_MC     4'h4
`define MFESD_MODE_AVC_IT     4'h7
`define MFESD_MODE_VC1_IT     4'hB

`define MFESD_FC_BV_MSB       31
`define MFESD_FC_BH_MSB       27
`define MFESD_FC_FV_MSB       23
`define MFESD_FC_FH_MSB       19
`define MFESD_DCP_MSB         15
`define MFESD_DCP_LSB         14
`define MFESD_PS_MSB          13
`define MFESD_PS_LSB          12
`define MFESD_TFF_BIT         11
`define MFESD_FPFD_BIT        10
`define MFESD_CMV_BIT         9
`define MFESD_QST_BIT         8
`define MFESD_IVLC_BIT        7
`define MFESD_ALTSCAN_BIT     6

`define MFESD_PS_TOP          2'h1
`define MFESD_PS_BOTTOM       2'h2
`define MFESD_PS_FRAME        2'h3

`endif

// >>> hw/mfesd_picture_decode.v
// Purpose: Registers the decode-descriptor picture parameters for the variable_length_decoder.
// Assumes: Word zero of the decode_state_descriptor and the mode gate arrive on the same clock.
// Notes:   All outputs hold zero while the gate is low.
`timescale 1ns/1ps
`include "mfesd_defines.vh"

module mfesd_picture_decode (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        enable_i,
  input  wire [31:0] dsd_w0_i,
  output reg  [15:0] f_codes_o,
  output reg  [1:0]  intra_dc_precision_o,
  output reg         structure_top_field_o,
  output reg         structure_bottom_field_o,
  output reg         structure_frame_o,
  output reg         structure_reserved_o,
  output reg         field_order_bit_o,
  output reg         top_field_first_out_o,
  output reg         second_field_o,
  output reg         quant_scale_nonlinear_o,
  output reg         intra_vlc_table_o,
  output reg         frame_dct_only_o,
  output reg         conceal_mv_o,
  output reg         alternate_scan_o
);

  wire [31:0] word_w = enable_i ? dsd_w0_i : 32'h00000000;
  wire [1:0]  ps_w   = word_w[`MFESD_PS_MSB:`MFESD_PS_LSB];
  wire        tff_w  = word_w[`MFESD_TFF_BIT];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f_codes_o                <= 16'h0000;
      intra_dc_precision_o     <= 2'h0;
      structure_top_field_o    <= 1'b0;
      structure_bottom_field_o <= 1'b0;
      structure_frame_o        <= 1'b0;
      structure_reserved_o     <= 1'b0;
      field_order_bit_o        <= 1'b0;
      top_field_first_out_o    <= 1'b0;
      second_field_o           <= 1'b0;
      quant_scale_nonlinear_o  <= 1'b0;
      intra_vlc_table_o        <= 1'b0;
      frame_dct_only_o         <= 1'b0;
      conceal_mv_o             <= 1'b0;
      alternate_scan_o         <= 1'b0;
    end else begin
      f_codes_o                <= word_w[`MFESD_FC_BV_MSB:`MFESD_FC_FH_MSB-3];
      intra_dc_precision_o     <= word_w[`MFESD_DCP_MSB:`MFESD_DCP_LSB];
      structure_top_field_o    <= (ps_w == `MFESD_PS_TOP);
      structure_bottom_field_o <= (ps_w == `MFESD_PS_BOTTOM);
      structure_frame_o        <= (ps_w == `MFESD_PS_FRAME);
      structure_reserved_o     <= (ps_w == 2'h0) & enable_i;
      field_order_bit_o        <= tff_w;
      top_field_first_out_o    <= (ps_w == `MFESD_PS_FRAME) & tff_w;
      second_field_o           <= ((ps_w == `MFESD_PS_TOP) & ~tff_w) |
                                  ((ps_w == `MFESD_PS_BOTTOM) & tff_w);
      quant_scale_nonlinear_o  <= word_w[`MFESD_QST_BIT];
      intra_vlc_table_o        <= word_w[`MFESD_IVLC_BIT];
      frame_dct_only_o         <= word_w[`MFESD_FPFD_BIT];
      conceal_mv_o             <= word_w[`MFESD_CMV_BIT];
      alternate_scan_o         <= word_w[`MFESD_ALTSCAN_BIT];
    end
  end

endmodule

// >>> hw/mfesd_state_decode.v
// Purpose: Holds and decodes the front end state and decode state descriptors behind a Wishbone slave.
// Assumes: One clock; command streamer and thread spawner logic run on it.
// Notes:   Writes take effect on the acknowledged edge; ack comes one cycle after the request.
`timescale 1ns/1ps
`include "mfesd_defines.vh"

// Operation
// - Scratch base is word zero bits 31:10, 1 KB aligned, plus state base.
// - Extension bit clear loads nothing; set loads extended state from its pointer.
// - Per-thread scratch code 0 to 11 means 1 KB to 12 KB linearly.
// - Active root threads are limited to the seven-bit field plus one.
// - Return-buffer entry size is nine-bit field plus one registers, 0 to 255 valid.
// - Return-buffer entry count is a seven-bit field, legal 1 to 64.
// - Mode codes: generic, decode, inverse scan, AVC MC, AVC IT, VC-1 IT.
// - Children-present bit lets root threads send spawn messages.
// - Kernel-descriptor base is word two bits 31:4 plus state base.
// - Four motion-vector range codes: backward pair on top, forward pair below.
// - Intra DC precision is the two-bit field at bits 15:14.
// - Picture structure: 01 top, 10 bottom, 11 frame, 00 reserved.
// - Frame picture with field-order bit set outputs top field first.
// - Field pictures infer second field from the field-order bit.
// - Scale-type bit zero is linear, one is nonlinear quantizer scaling.
// - Intra table selector bit picks the decoder's intra coefficient table.
// - Without extended state, kernel index remapping is bypassed.
module mfesd_state_decode #(
  parameter MAX_ROOT_THREADS = 128
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        root_req_i,
  input  wire        root_retire_i,
  input  wire        spawn_req_i,
  output reg         root_grant_o,
  output reg         spawn_grant_o,
  output reg         spawn_refused_o,
  output reg         ext_load_o,
  output reg  [31:0] ext_ptr_o,
  output reg  [31:0] scratch_base_o,
  output reg  [13:0] scratch_bytes_o,
  output reg  [7:0]  root_limit_o,
  output reg  [8:0]  urb_entry_regs_o,
  output reg  [6:0]  urb_entries_o,
  output reg  [5:0]  mode_onehot_o,
  output reg         mode_reserved_o,
  output reg  [31:0] kernel_desc_addr_o,
  output reg         remap_bypass_o,
  output reg  [15:0] f_codes_o,
  output reg  [1:0]  intra_dc_precision_o,
  output reg         structure_top_field_o,
  output reg         structure_bottom_field_o,
  output reg         structure_frame_o,
  output reg         second_field_o,
  output reg         top_field_first_out_o,
  output reg         quant_scale_nonlinear_o,
  output reg         intra_vlc_table_o
);

  reg         rst_meta_reg;
  reg         rst_sync_reg;
  reg  [31:0] fes_w0_reg;
  reg  [31:0] fes_w1_reg;
  reg  [31:0] fes_w2_reg;
  reg  [31:0] dsd_w0_reg;
  reg  [31:0] dsd_w1_reg;
  reg  [31:0] gs_base_reg;
  reg  [31:0] ext_ptr_reg;
  reg  [31:0] index_reg;
  reg  [7:0]  active_reg;
  reg  [7:0]  active_next;
  reg         grant_now;
  reg  [31:0] rd_data;
  wire        wb_req;
  wire        wb_wr;
  wire [3:0]  mode_w;
  wire [7:0]  limit_w;
  wire        is_vld_w;
  wire [15:0] pp_f_codes;
  wire [1:0]  pp_dcp;
  wire        pp_top;
  wire        pp_bottom;
  wire        pp_frame;
  wire        pp_ps_res;
  wire        pp_tff_out;
  wire        pp_second;
  wire        pp_qnl;
  wire        pp_ivlc;

  // Merges write data into a word under the byte enables.
  function [31:0] merge_bytes;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  sel;
    integer      k;
    begin
      merge_bytes = old_w;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge_bytes[8*k +: 8] = new_w[8*k +: 8];
        end
      end
    end
  endfunction

  // Decodes the operating mode code into one flag per documented mode.
  function [5:0] mode_decode;
    input [3:0] code;
    begin
      mode_decode = {code == `MFESD_MODE_VC1_IT, code == `MFESD_MODE_AVC_IT, code == `MFESD_MODE_AVC_MC,
                     code == `MFESD_MODE_IS, code == `MFESD_MODE_VLD, code == `MFESD_MODE_GENERIC};
    end
  endfunction

  // Releases the reset synchronously to the clock.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr    = wb_req & wb_we_i;
  assign mode_w   = fes_w1_reg[`MFESD_MODE_MSB:`MFESD_MODE_LSB];
  assign limit_w  = {1'b0, fes_w1_reg[`MFESD_THR_MSB:`MFESD_THR_LSB]} + 8'h01;
  assign is_vld_w = (mode_w == `MFESD_MODE_VLD);

  // Register writes and bus acknowledge.
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      fes_w0_reg  <= `MFESD_WORD_RESET;
      fes_w1_reg  <= `MFESD_WORD_RESET;
      fes_w2_reg  <= `MFESD_WORD_RESET;
      dsd_w0_reg  <= `MFESD_WORD_RESET;
      dsd_w1_reg  <= `MFESD_WORD_RESET;
      gs_base_reg <= `MFESD_WORD_RESET;
      ext_ptr_reg <= `MFESD_WORD_RESET;
      index_reg   <= `MFESD_WORD_RESET;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h00000000;
      if (wb_wr) begin
        case (wb_adr_i)
          `MFESD_ADDR_FES_W0: begin
            fes_w0_reg <= merge_bytes(fes_w0_reg, wb_dat_i, wb_sel_i);
          end
          `MFESD_ADDR_FES_W1: begin
            fes_w1_reg <= merge_bytes(fes_w1_reg, wb_dat_i, wb_sel_i);
          end
          `MFESD_ADDR_FES_W2: begin
            fes_w2_reg <= merge_bytes(fes_w2_reg, wb_dat_i, wb_sel_i);
          end
          `MFESD_ADDR_DSD_W0: begin
            dsd_w0_reg <= merge_bytes(dsd_w0_reg, wb_dat_i, wb_sel_i);
          end
          `MFESD_ADDR_DSD_W1: begin
            dsd_w1_reg <= merge_bytes(dsd_w1_reg, wb_dat_i, wb_sel_i);
          end
          `MFESD_ADDR_GS_BASE: begin
            gs_base_reg <= merge_bytes(gs_base_reg, wb_dat_i, wb_sel_i);
          end
          `MFESD_ADDR_EXT_PTR: begin
            ext_ptr_reg <= merge_bytes(ext_ptr_reg, wb_dat_i, wb_sel_i);
          end
          `MFESD_ADDR_INDEX: begin
            index_reg <= merge_bytes(index_reg, wb_dat_i, wb_sel_i);
          end
          default: begin
            index_reg <= index_reg;
          end
        endcase
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always @* begin
    case (wb_adr_i)
      `MFESD_ADDR_FES_W0:   rd_data = fes_w0_reg;
      `MFESD_ADDR_FES_W1:   rd_data = fes_w1_reg;
      `MFESD_ADDR_FES_W2:   rd_data = fes_w2_reg;
      `MFESD_ADDR_DSD_W0:   rd_data = dsd_w0_reg;
      `MFESD_ADDR_DSD_W1:   rd_data = dsd_w1_reg;
      `MFESD_ADDR_GS_BASE:  rd_data = gs_base_reg;
      `MFESD_ADDR_EXT_PTR:  rd_data = ext_ptr_reg;
      `MFESD_ADDR_INDEX:    rd_data = index_reg;
      `MFESD_ADDR_STATUS:   rd_data = {16'h0000, mode_reserved_o, pp_ps_res, 6'h00, active_reg};
      default:              rd_data = 32'h00000000;
    endcase
  end

  // Root thread admission and active count.
  always @* begin
    grant_now   = root_req_i & (active_reg < limit_w);
    active_next = active_reg;
    if (grant_now & ~root_retire_i) begin
      active_next = active_reg + 8'h01;
    end else if (~grant_now & root_retire_i & (active_reg != 8'h00)) begin
      active_next = active_reg - 8'h01;
    end
  end

  // Decoded state and thread control outputs.
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      active_reg         <= 8'h00;
      root_grant_o       <= 1'b0;
      spawn_grant_o      <= 1'b0;
      spawn_refused_o    <= 1'b0;
      ext_load_o         <= 1'b0;
      ext_ptr_o          <= 32'h00000000;
      scratch_base_o     <= 32'h00000000;
      scratch_bytes_o    <= 14'h0000;
      root_limit_o       <= 8'h00;
      urb_entry_regs_o   <= 9'h000;
      urb_entries_o      <= 7'h00;
      mode_onehot_o      <= 6'h00;
      mode_reserved_o    <= 1'b0;
      kernel_desc_addr_o <= 32'h00000000;
      remap_bypass_o     <= 1'b1;
    end else begin
      active_reg      <= active_next;
      root_grant_o    <= grant_now;
      spawn_grant_o   <= spawn_req_i & fes_w1_reg[`MFESD_CHILD_BIT];
      spawn_refused_o <= spawn_req_i & ~fes_w1_reg[`MFESD_CHILD_BIT];
      ext_load_o      <= wb_wr & (wb_adr_i == `MFESD_ADDR_APPLY) & wb_dat_i[0] &
                         fes_w0_reg[`MFESD_EXT_BIT];
      ext_ptr_o       <= fes_w0_reg[`MFESD_EXT_BIT] ? ext_ptr_reg : 32'h00000000;
      scratch_base_o  <= gs_base_reg + {fes_w0_reg[`MFESD_SCRATCH_MSB:`MFESD_SCRATCH_LSB], 10'h000};
      scratch_bytes_o <= {(fes_w0_reg[`MFESD_PTS_MSB:`MFESD_PTS_LSB] + 4'h1) &
                          {4{fes_w0_reg[`MFESD_PTS_MSB:`MFESD_PTS_LSB] <= `MFESD_PTS_MAX}}, 10'h000};
      root_limit_o    <= limit_w;
      urb_entry_regs_o <= fes_w1_reg[`MFESD_URB_SIZE_MSB:`MFESD_URB_SIZE_LSB] + 9'h001;
      urb_entries_o   <= fes_w1_reg[`MFESD_URB_CNT_MSB:`MFESD_URB_CNT_LSB];
      mode_onehot_o   <= mode_decode(mode_w);
      mode_reserved_o <= ~(|mode_decode(mode_w)) |
                        (fes_w1_reg[`MFESD_URB_SIZE_MSB:`MFESD_URB_SIZE_LSB] > `MFESD_URB_SIZE_MAX) |
                        (fes_w1_reg[`MFESD_URB_CNT_MSB:`MFESD_URB_CNT_LSB] < `MFESD_URB_CNT_MIN) |
                        (fes_w1_reg[`MFESD_URB_CNT_MSB:`MFESD_URB_CNT_LSB] > `MFESD_URB_CNT_MAX);
      kernel_desc_addr_o <= gs_base_reg + {fes_w2_reg[`MFESD_KD_MSB:`MFESD_KD_LSB], 4'h0} +
                            {index_reg[27:0], 4'h0};
      remap_bypass_o  <= ~fes_w0_reg[`MFESD_EXT_BIT];
    end
  end

  mfesd_picture_decode u_picture_decode (
    .clk_i                    (clk_i),
    .rst_n_i                  (rst_sync_reg),
    .enable_i                 (is_vld_w),
    .dsd_w0_i                 (dsd_w0_reg),
    .f_codes_o                (pp_f_codes),
    .intra_dc_precision_o     (pp_dcp),
    .structure_top_field_o    (pp_top),
    .structure_bottom_field_o (pp_bottom),
    .structure_frame_o        (pp_frame),
    .structure_reserved_o     (pp_ps_res),
    .field_order_bit_o        (),
    .top_field_first_out_o    (pp_tff_out),
    .second_field_o           (pp_second),
    .quant_scale_nonlinear_o  (pp_qnl),
    .intra_vlc_table_o        (pp_ivlc),
    .frame_dct_only_o         (),
    .conceal_mv_o             (),
    .alternate_scan_o         ()
  );

  // Retimes the picture parameters onto top-level flops.
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      f_codes_o                <= 16'h0000;
      intra_dc_precision_o     <= 2'h0;
      structure_top_field_o    <= 1'b0;
      structure_bottom_field_o <= 1'b0;
      structure_frame_o        <= 1'b0;
      second_field_o           <= 1'b0;
      top_field_first_out_o    <= 1'b0;
      quant_scale_nonlinear_o  <= 1'b0;
      intra_vlc_table_o        <= 1'b0;
    end else begin
      f_codes_o                <= pp_f_codes;
      intra_dc_precision_o     <= pp_dcp;
      structure_top_field_o    <= pp_top;
      structure_bottom_field_o <= pp_bottom;
      structure_frame_o        <= pp_frame;
      second_field_o           <= pp_second;
      top_field_first_out_o    <= pp_tff_out;
      quant_scale_nonlinear_o  <= pp_qnl;
      intra_vlc_table_o        <= pp_ivlc;
    end
  end

endmodule

// >>> testbench/mfesd_spawner_model.sv
// Purpose: Behavioural thread spawner side of the decoder.
// Assumes: Requests are one-cycle pulses answered one cycle later.
// Notes:   Counts every grant and refusal it receives.
`timescale 1ns/1ps
module mfesd_spawner_model (
  input  wire logic clk_i,
  input  wire logic root_grant_i,
  input  wire logic spawn_grant_i,
  input  wire logic spawn_refused_i,
  output logic      root_req_o,
  output logic      root_retire_o,
  output logic      spawn_req_o
);
  integer grants = 0;
  integer spawn_ok = 0;
  integer spawn_no = 0;
  initial begin
    root_req_o = 1'b0;
    root_retire_o = 1'b0;
    spawn_req_o = 1'b0;
  end
  always @(posedge clk_i) begin
    grants <= grants + (root_grant_i === 1'b1);
    spawn_ok <= spawn_ok + (spawn_grant_i === 1'b1);
    spawn_no <= spawn_no + (spawn_refused_i === 1'b1);
  end
  // Sends n back-to-back pulses: kind 0 root request, 1 retirement, 2 spawn message.
  task automatic pulse(input integer kind, input integer n);
    integer j;
    for (j = 0; j < n; j++) begin
      @(posedge clk_i);
      root_req_o <= (kind == 0);
      root_retire_o <= (kind == 1);
      spawn_req_o <= (kind == 2);
    end
    @(posedge clk_i);
    root_req_o <= 1'b0;
    root_retire_o <= 1'b0;
    spawn_req_o <= 1'b0;
  endtask
endmodule

// >>> testbench/mfesd_state_decode_assertions.sv
// Purpose: Concurrent checks on the ports of the media front end state decoder.
// Assumes: One clock; outputs settle a few cycles after reset release.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ps
module mfesd_state_decode_assertions (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        root_req_i,
  input wire logic        spawn_req_i,
  input wire logic        root_grant_o,
  input wire logic        spawn_grant_o,
  input wire logic        spawn_refused_o,
  input wire logic        ext_load_o,
  input wire logic [31:0] ext_ptr_o,
  input wire logic [13:0] scratch_bytes_o,
  input wire logic [5:0]  mode_onehot_o,
  input wire logic        mode_reserved_o,
  input wire logic        remap_bypass_o,
  input wire logic [15:0] f_codes_o,
  input wire logic [1:0]  intra_dc_precision_o,
  input wire logic        structure_top_field_o,
  input wire logic        structure_bottom_field_o,
  input wire logic        structure_frame_o,
  input wire logic        second_field_o,
  input wire logic        top_field_first_out_o,
  input wire logic        quant_scale_nonlinear_o,
  input wire logic        intra_vlc_table_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h00000000; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
  property p_scratch_lin; scratch_bytes_o[9:0] == 10'h000 && scratch_bytes_o <= 14'h3000; endproperty
  a_scratch_lin: assert property (p_scratch_lin) else $error("scratch size not linear KB");
  property p_bypass; remap_bypass_o |-> ext_ptr_o == 32'h00000000 && !ext_load_o; endproperty
  a_bypass: assert property (p_bypass) else $error("extended state used while absent");
  property p_mode; $onehot0(mode_onehot_o) && (!$past(rst_n_i, 5) || mode_onehot_o != 6'h00 || mode_reserved_o);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode inconsistent");
  property p_struct; $onehot0({structure_top_field_o, structure_bottom_field_o, structure_frame_o}); endproperty
  a_struct: assert property (p_struct) else $error("picture structure not one-hot");
  property p_second; second_field_o |-> structure_top_field_o || structure_bottom_field_o; endproperty
  a_second: assert property (p_second) else $error("second field outside field picture");
  property p_tff; top_field_first_out_o |-> structure_frame_o; endproperty
  a_tff: assert property (p_tff) else $error("top field first outside frame picture");
  property p_pic_gate; !$past(mode_onehot_o[1]) |-> {f_codes_o, intra_dc_precision_o, quant_scale_nonlinear_o,
    intra_vlc_table_o, structure_top_field_o, structure_bottom_field_o, structure_frame_o} == 23'h0; endproperty
  a_pic_gate: assert property (p_pic_gate) else $error("picture parameters outside decode mode");
  property p_grant; root_grant_o |-> $past(root_req_i); endproperty
  a_grant: assert property (p_grant) else $error("root grant without request");
  property p_spawn; spawn_req_i |=> spawn_grant_o ^ spawn_refused_o; endproperty
  a_spawn: assert property (p_spawn) else $error("spawn message not answered once");
endmodule

// >>> testbench/test_media_front_end_state_decode.sv
// Purpose: Self-checking bench for the media front end state decoder.
// Assumes: Outputs settle within three cycles of a write.
// Notes:   Expected values come from a register model kept in this file.
`timescale 1ns/1ps
module test_media_front_end_state_decode;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  wire logic   root_req_i, root_retire_i, spawn_req_i;
  logic [31:0] wb_dat_o, ext_ptr_o, scratch_base_o, kernel_desc_addr_o, q, w0, w1, d0, m [0:9];
  logic        wb_ack_o, root_grant_o, spawn_grant_o, spawn_refused_o, ext_load_o, mode_reserved_o, remap_bypass_o;
  logic        structure_top_field_o, structure_bottom_field_o, structure_frame_o, second_field_o;
  logic        top_field_first_out_o, quant_scale_nonlinear_o, intra_vlc_table_o, vld;
  logic [13:0] scratch_bytes_o;
  logic [7:0]  root_limit_o;
  logic [8:0]  urb_entry_regs_o, sz;
  logic [6:0]  urb_entries_o, cnt;
  logic [5:0]  mode_onehot_o, oh;
  logic [15:0] f_codes_o;
  logic [1:0]  intra_dc_precision_o;
  logic [3:0]  modes [0:7];
  integer      miscompares = 0, checked = 0, cycles = 0, ext_loads = 0, i, k;

  mfesd_state_decode DUT (.*);
  mfesd_spawner_model partner (.clk_i(clk_i), .root_grant_i(root_grant_o), .spawn_grant_i(spawn_grant_o),
    .spawn_refused_i(spawn_refused_o), .root_req_o(root_req_i), .root_retire_o(root_retire_i),
    .spawn_req_o(spawn_req_i));

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    ext_loads += (ext_load_o === 1'b1);
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
    wb(1'b1, a, d, s);
    if (a <= 6'h18 || a == 6'h24)
      for (int b = 0; b < 4; b++)
        if (s[b]) m[a[5:2]][8*b +: 8] = d[8*b +: 8];
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000, 4'hF);
    check("read data", q, exp);
  endtask
  task automatic readback();
    for (k = 0; k < 7; k++)
      rd(6'(k * 4), m[k]);
  endtask
  task automatic outs();
    repeat (3) @(posedge clk_i);
    w0 = m[0];
    w1 = m[1];
    d0 = m[3];
    case (w1[6:3])
      4'h0: oh = 6'h01;
      4'h1: oh = 6'h02;
      4'h2: oh = 6'h04;
      4'h4: oh = 6'h08;
      4'h7: oh = 6'h10;
      4'hB: oh = 6'h20;
      default: oh = 6'h00;
    endcase
    vld = oh[1];
    check("scratch_base", scratch_base_o, m[5] + {w0[31:10], 10'h000});
    check("scratch_bytes", scratch_bytes_o, w0[3:0] <= 4'hB ? (w0[3:0] + 1) * 1024 : 0);
    check("ext_ptr", ext_ptr_o, w0[7] ? m[6] : 32'h0);
    check("remap_bypass", remap_bypass_o, !w0[7]);
    check("root_limit", root_limit_o, w1[31:25] + 1);
    check("urb_entry_regs", urb_entry_regs_o, w1[24:16] + 1);
    check("urb_entries", urb_entries_o, w1[15:9]);
    check("mode_onehot", mode_onehot_o, oh);
    check("mode_reserved", mode_reserved_o, oh == 0 || w1[24:16] > 255 || w1[15:9] < 1 || w1[15:9] > 64);
    check("kernel_desc", kernel_desc_addr_o, m[5] + {m[2][31:4], 4'h0} + m[9] * 16);
    check("f_codes", f_codes_o, vld ? d0[31:16] : 0);
    check("picture", {intra_dc_precision_o, structure_top_field_o, structure_bottom_field_o, structure_frame_o,
      second_field_o, top_field_first_out_o, quant_scale_nonlinear_o, intra_vlc_table_o},
      vld ? {d0[15:14], d0[13:12] == 2'h1, d0[13:12] == 2'h2, d0[13:12] == 2'h3,
      (d0[13:12] == 2'h1 && !d0[11]) || (d0[13:12] == 2'h2 && d0[11]), d0[13:12] == 2'h3 && d0[11], d0[8], d0[7]}
      : 0);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hA887E3C5));
    modes = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7, 4'hB, 4'h3, 4'hF};
    m = '{default: 32'h00000000};
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    outs();
    readback();
    $display("test reset done");
    for (i = 0; i < 12; i++) begin
      sz = (i == 0) ? 9'h0FF : (i == 4) ? 9'h100 : 9'($urandom_range(255, 0));
      cnt = (i == 1) ? 7'h00 : (i == 2) ? 7'h41 : (i == 3) ? 7'h40 : 7'($urandom_range(64, 1));
      wr(6'h14, $urandom, 4'hF);
      wr(6'h18, $urandom, 4'hF);
      wr(6'h00, {22'($urandom), 2'b00, 1'($urandom), 3'b000, 4'(i)}, 4'hF);
      wr(6'h04, {1'b0, 6'($urandom), sz, cnt, 2'b00, modes[i % 8], (modes[i % 8] != 4'h1) & 1'($urandom),
        2'b00}, 4'hF);
      wr(6'h08, {28'($urandom), 4'h0}, 4'hF);
      wr(6'h24, 32'($urandom_range(15, 0)), 4'hF);
      wr(6'h0C, $urandom, 4'hF);
      wr(6'h10, $urandom, 4'hF);
      outs();
      readback();
    end
    $display("test decode done");
    wr(6'h04, 32'h00000208, 4'hF);
    for (k = 0; k < 8; k++) begin
      wr(6'h0C, {18'($urandom), 3'(k), 11'($urandom)}, 4'hF);
      outs();
    end
    $display("test picture done");
    wr(6'h00, 32'hFFFFFFFF, 4'h5);
    wr(6'h2C, $urandom, 4'hF);
    rd(6'h2C, 32'h00000000);
    wr(6'h1C, 32'h00000000, 4'hF);
    rd(6'h1C, 32'h00000000);
    outs();
    readback();
    $display("test bus done");
    wr(6'h04, {7'd2, 9'd0, 7'd1, 2'b00, 4'h0, 1'b1, 2'b00}, 4'hF);
    partner.pulse(0, 5);
    repeat (2) @(posedge clk_i);
    check("root grants", partner.grants, 3);
    rd(6'h20, 32'h00000003);
    partner.pulse(1, 1);
    partner.pulse(0, 2);
    partner.pulse(2, 2);
    repeat (2) @(posedge clk_i);
    check("root grants", partner.grants, 4);
    check("spawn grants", partner.spawn_ok, 2);
    wr(6'h04, {7'd2, 9'd0, 7'd1, 2'b00, 4'h0, 1'b0, 2'b00}, 4'hF);
    partner.pulse(2, 1);
    repeat (2) @(posedge clk_i);
    check("spawn refusals", partner.spawn_no, 1);
    $display("test threads done");
    wr(6'h00, 32'h00000080, 4'hF);
    wr(6'h1C, 32'h00000001, 4'hF);
    wr(6'h00, 32'h00000000, 4'hF);
    wr(6'h1C, 32'h00000001, 4'hF);
    repeat (3) @(posedge clk_i);
    check("ext loads", ext_loads, 1);
    outs();
    $display("test extension done");
    finish_test();
  end
endmodule
bind mfesd_state_decode mfesd_state_decode_assertions u_checker (.*);
